// File: hdl/hc_misc_buffer_config_regs.sv
// Purpose: misc and buffer sizing registers of the host controller
// Assumes: command then data phases on the shared bus, pulses sync to i_core_clk
// Notes: soft reset clears registers here and is passed on; buffer RAM untouched
// Notes: latched command survives soft reset, so the driver need not re-issue it
// Overview of operation
// RULE_01 - Read command 27 returns a fixed 16-bit id word whose upper byte names the product.
// RULE_02 - The lower byte of the id word carries the silicon revision number.
// RULE_03 - A 16-bit scratch register reads on 28, writes on A8, resets to zero, no side effects.
// RULE_04 - Writing F6H with command A9 resets all controller registers but keeps buffer memory.
// RULE_05 - The iso buffer length register reads on 2A, writes on AA and resets to zero.
// RULE_06 - The single iso length sizes both iso buffers equally.
// RULE_07 - The async buffer length register reads on 2B, writes on AB and resets to zero.
// RULE_08 - Software keeps async length plus twice the iso length within the shared RAM.
// RULE_09 - Writing any other value to the soft reset register changes nothing.
`timescale 1ns/1ps
module hc_misc_buffer_config_regs
  import hc_regs_pkg::*;
#(
  parameter logic [7:0] PRODUCT_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h01, // arbitrary value
  parameter int unsigned RAM_BYTES = BUFFER_RAM_BYTES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // command phase: code on i_bus_data[7:0]
  input wire logic i_cmd_wr,
  // data phases
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire logic [DATA_W-1:0] i_bus_data,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_rd_valid,
  // register contents to the rest of the controller
  output logic [DATA_W-1:0] o_iso_len,
  output logic [DATA_W-1:0] o_async_len,
  output logic [DATA_W:0] o_iso_one_base,
  output logic [DATA_W:0] o_async_base,
  output logic [DATA_W+1:0] o_total_bytes,
  output logic o_layout_over,
  output logic o_soft_reset
);

  // the length registers cannot describe a RAM beyond the word range
  if (RAM_BYTES == 0 || RAM_BYTES > (1 << DATA_W)) begin : g_bad_ram_bytes
    $error("hc_misc_buffer_config_regs: RAM_BYTES out of range");
  end
  // command codes travel on the low lanes of the data bus
  if (CMD_W > DATA_W) begin : g_bad_cmd_w
    $error("hc_misc_buffer_config_regs: command wider than bus");
  end

  localparam logic [DATA_W-1:0] CHIP_ID = {PRODUCT_CODE, REVISION_CODE};

  // command tracking
  cmd_state_t state_q;
  cmd_state_t state_d;
  logic [CMD_W-1:0] cmd_q;
  logic [CMD_W-1:0] cmd_d;

  // storage
  logic [DATA_W-1:0] scratch_q;
  logic [DATA_W-1:0] scratch_d;
  logic [DATA_W-1:0] iso_len_q;
  logic [DATA_W-1:0] iso_len_d;
  logic [DATA_W-1:0] async_len_q;
  logic [DATA_W-1:0] async_len_d;
  logic soft_reset_q;
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic rd_valid_q;

  function automatic logic is_write_code(input logic [CMD_W-1:0] code);
    is_write_code = code[CMD_WRITE_BIT];
  endfunction : is_write_code

  function automatic logic hit(input logic [CMD_W-1:0] code, input logic [CMD_W-1:0] ref_code);
    hit = (code == ref_code);
  endfunction : hit

  // a data phase only counts once a command has been given
  wire cmd_open = (state_q == ST_CMD);
  wire wr_phase = cmd_open && i_data_wr && is_write_code(cmd_q);
  wire rd_phase = cmd_open && i_data_rd && !is_write_code(cmd_q);

  // write decode
  wire wr_scratch = wr_phase && hit(cmd_q, CMD_SCRATCH_WR); // RULE_03
  wire wr_iso_len = wr_phase && hit(cmd_q, CMD_ISO_LEN_WR); // RULE_05
  wire wr_async_len = wr_phase && hit(cmd_q, CMD_ASYNC_LEN_WR); // RULE_07
  wire wr_soft_reset = wr_phase && hit(cmd_q, CMD_SOFT_RESET_WR);
  // only the exact key fires; other values fall through harmlessly
  wire key_match = (i_bus_data == SOFT_RESET_KEY); // RULE_09
  wire soft_reset_fire = wr_soft_reset && key_match; // RULE_04

  // read decode
  wire rd_chip_id = hit(cmd_q, CMD_CHIP_ID_RD); // RULE_01
  wire rd_scratch = hit(cmd_q, CMD_SCRATCH_RD); // RULE_03
  wire rd_iso_len = hit(cmd_q, CMD_ISO_LEN_RD); // RULE_05
  wire rd_async_len = hit(cmd_q, CMD_ASYNC_LEN_RD); // RULE_07

  // read mux; unmapped codes answer zero
  always_comb begin
    rd_data_d = UNMAPPED_READ;
    if (rd_chip_id) begin
      rd_data_d = CHIP_ID; // RULE_01 RULE_02
    end else if (rd_scratch) begin
      rd_data_d = scratch_q;
    end else if (rd_iso_len) begin
      rd_data_d = iso_len_q;
    end else if (rd_async_len) begin
      rd_data_d = async_len_q;
    end
  end

  // command state: a new command may follow any number of data phases
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    case (state_q)
      ST_IDLE: begin
        if (i_cmd_wr) begin
          state_d = ST_CMD;
          cmd_d = i_bus_data[CMD_W-1:0];
        end
      end
      ST_CMD: begin
        if (i_cmd_wr) begin
          cmd_d = i_bus_data[CMD_W-1:0];
        end
      end
      // a corrupted state drops back to idle and waits for a command
      default: begin
        state_d = ST_IDLE;
        cmd_d = '0;
      end
    endcase
  end

  // register next values; soft reset clears them like a hard reset
  always_comb begin
    scratch_d = scratch_q;
    iso_len_d = iso_len_q;
    async_len_d = async_len_q;
    if (soft_reset_fire) begin
      scratch_d = SCRATCH_RESET; // RULE_04
      iso_len_d = ISO_LEN_RESET; // RULE_04
      async_len_d = ASYNC_LEN_RESET; // RULE_04
    end else begin
      if (wr_scratch) begin
        scratch_d = i_bus_data; // RULE_03
      end
      if (wr_iso_len) begin
        iso_len_d = i_bus_data; // RULE_05
      end
      if (wr_async_len) begin
        async_len_d = i_bus_data; // RULE_07
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      cmd_q <= '0;
    end else begin
      state_q <= state_d;
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      scratch_q <= SCRATCH_RESET;
      iso_len_q <= ISO_LEN_RESET;
      async_len_q <= ASYNC_LEN_RESET;
    end else begin
      scratch_q <= scratch_d;
      iso_len_q <= iso_len_d;
      async_len_q <= async_len_d;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= soft_reset_fire; // RULE_04
    end
  end

  // read data registered; holds its last value between reads
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_q <= UNMAPPED_READ;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_phase;
      if (rd_phase) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  // layout uses the live lengths; soft reset clears it in step
  buffer_partition #(
    .RAM_BYTES(RAM_BYTES)
  ) u_partition (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_soft_reset(soft_reset_q),
    .i_iso_len(iso_len_q),
    .i_async_len(async_len_q),
    .o_iso_one_base(o_iso_one_base),
    .o_async_base(o_async_base),
    .o_total_bytes(o_total_bytes),
    .o_layout_over(o_layout_over)
  );

  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_iso_len = iso_len_q;
  assign o_async_len = async_len_q;
  // one-cycle pulse so the other controller registers clear too
  assign o_soft_reset = soft_reset_q; // RULE_04

endmodule : hc_misc_buffer_config_regs

// File: hdl/hc_regs_pkg.sv
// Purpose: shared constants for the host controller misc/buffer register bank
// Assumes: 8-bit command codes, 16-bit data words
// Notes: read codes have bit 7 clear, write codes have bit 7 set
package hc_regs_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned CMD_W = 8;

  // command codes
  localparam logic [CMD_W-1:0] CMD_CHIP_ID_RD = 8'h27;
  localparam logic [CMD_W-1:0] CMD_SCRATCH_RD = 8'h28;
  localparam logic [CMD_W-1:0] CMD_SCRATCH_WR = 8'ha8;
  localparam logic [CMD_W-1:0] CMD_SOFT_RESET_WR = 8'ha9;
  localparam logic [CMD_W-1:0] CMD_ISO_LEN_RD = 8'h2a;
  localparam logic [CMD_W-1:0] CMD_ISO_LEN_WR = 8'haa;
  localparam logic [CMD_W-1:0] CMD_ASYNC_LEN_RD = 8'h2b;
  localparam logic [CMD_W-1:0] CMD_ASYNC_LEN_WR = 8'hab;

  // write-direction flag inside a command code
  localparam int unsigned CMD_WRITE_BIT = 7;

  // reset values and key
  localparam logic [DATA_W-1:0] SCRATCH_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ISO_LEN_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ASYNC_LEN_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] SOFT_RESET_KEY = 16'h00f6;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 16'h0000;

  // identification word layout
  localparam int unsigned ID_PRODUCT_LSB = 8;
  localparam int unsigned ID_BYTE_W = 8;

  // shared buffer RAM size in bytes
  localparam int unsigned BUFFER_RAM_BYTES = 4096;

  // command tracker states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CMD = 2'b10
  } cmd_state_t;

endpackage : hc_regs_pkg

// File: hdl/buffer_partition.sv
// Purpose: place the two iso buffers and the async buffer in the shared RAM
// Assumes: lengths are byte counts, iso buffers laid out first
// Notes: registered outputs; overflow is only reported, never corrected
`timescale 1ns/1ps
module buffer_partition
  import hc_regs_pkg::*;
#(
  parameter int unsigned RAM_BYTES = BUFFER_RAM_BYTES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_soft_reset,
  input wire logic [DATA_W-1:0] i_iso_len,
  input wire logic [DATA_W-1:0] i_async_len,
  output logic [DATA_W:0] o_iso_one_base,
  output logic [DATA_W:0] o_async_base,
  output logic [DATA_W+1:0] o_total_bytes,
  output logic o_layout_over
);

  localparam logic [DATA_W+1:0] RAM_LIMIT = (DATA_W+2)'(RAM_BYTES);

  if (RAM_BYTES == 0 || RAM_BYTES > (1 << DATA_W)) begin : g_bad_ram_bytes
    $error("buffer_partition: RAM_BYTES out of range");
  end

  function automatic logic [DATA_W:0] twice(input logic [DATA_W-1:0] len);
    twice = {len, 1'b0};
  endfunction : twice

  // both iso buffers get the same length
  wire [DATA_W:0] iso_one_base_d = {1'b0, i_iso_len}; // RULE_06
  wire [DATA_W:0] async_base_d = twice(i_iso_len); // RULE_06
  wire [DATA_W+1:0] total_d = {1'b0, async_base_d} + {2'b00, i_async_len};
  // software owns the budget; hardware only flags a breach
  wire over_d = total_d > RAM_LIMIT; // RULE_08

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_iso_one_base <= '0;
      o_async_base <= '0;
      o_total_bytes <= '0;
      o_layout_over <= 1'b0;
    end else if (i_soft_reset) begin
      o_iso_one_base <= '0;
      o_async_base <= '0;
      o_total_bytes <= '0;
      o_layout_over <= 1'b0;
    end else begin
      o_iso_one_base <= iso_one_base_d;
      o_async_base <= async_base_d;
      o_total_bytes <= total_d;
      o_layout_over <= over_d;
    end
  end

endmodule : buffer_partition

// File: dv/hc_regs_checker.sv
// Purpose: port checks for hc_misc_buffer_config_regs
// Assumes: one clock, async active-high reset
// Notes: tracks the latched command itself
`timescale 1ns/1ps
module hc_regs_checker
  import hc_regs_pkg::*;
#(
  parameter logic [7:0] PRODUCT_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h01 // arbitrary value
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cmd_wr,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire logic [DATA_W-1:0] i_bus_data,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic [DATA_W-1:0] o_iso_len,
  input wire logic [DATA_W-1:0] o_async_len,
  input wire logic [DATA_W:0] o_iso_one_base,
  input wire logic [DATA_W:0] o_async_base,
  input wire logic o_soft_reset
);
  logic [CMD_W-1:0] cmd_q;
  wire logic key_wr = i_data_wr && cmd_q == CMD_SOFT_RESET_WR && i_bus_data == SOFT_RESET_KEY;
  wire logic iso_wr = i_data_wr && cmd_q == CMD_ISO_LEN_WR;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= 8'h00;
    end else if (i_cmd_wr) begin
      cmd_q <= i_bus_data[CMD_W-1:0];
    end
  end
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  property p_rd_cause;
    o_rd_valid |-> $past(i_data_rd) && !$past(cmd_q[CMD_WRITE_BIT]);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read answer without read");
  property p_id;
    o_rd_valid && $past(cmd_q) == CMD_CHIP_ID_RD |-> o_rd_data == {PRODUCT_CODE, REVISION_CODE};
  endproperty
  a_id: assert property (p_id) else $error("bad id word");
  property p_soft_cause;
    o_soft_reset |-> $past(key_wr);
  endproperty
  a_soft_cause: assert property (p_soft_cause) else $error("soft pulse without key");
  property p_soft_clear;
    o_soft_reset |-> o_iso_len == ISO_LEN_RESET && o_async_len == ASYNC_LEN_RESET;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("lengths kept");
  property p_iso_wr;
    iso_wr |=> o_iso_len == $past(i_bus_data);
  endproperty
  a_iso_wr: assert property (p_iso_wr) else $error("iso write lost");
  property p_async_wr;
    i_data_wr && cmd_q == CMD_ASYNC_LEN_WR |=> o_async_len == $past(i_bus_data);
  endproperty
  a_async_wr: assert property (p_async_wr) else $error("async write lost");
  property p_iso_hold;
    !iso_wr && !key_wr |=> $stable(o_iso_len);
  endproperty
  a_iso_hold: assert property (p_iso_hold) else $error("iso length moved");
  property p_layout;
    1'b1 |=> o_iso_one_base == {1'b0, $past(o_iso_len)} &&
      o_async_base == {$past(o_iso_len), 1'b0};
  endproperty
  a_layout: assert property (p_layout) else $error("bad buffer layout");
endmodule : hc_regs_checker
bind hc_misc_buffer_config_regs hc_regs_checker #(
  .PRODUCT_CODE(PRODUCT_CODE),
  .REVISION_CODE(REVISION_CODE)
) hc_regs_checker_i (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_cmd_wr(i_cmd_wr),
  .i_data_wr(i_data_wr),
  .i_data_rd(i_data_rd),
  .i_bus_data(i_bus_data),
  .o_rd_data(o_rd_data),
  .o_rd_valid(o_rd_valid),
  .o_iso_len(o_iso_len),
  .o_async_len(o_async_len),
  .o_iso_one_base(o_iso_one_base),
  .o_async_base(o_async_base),
  .o_soft_reset(o_soft_reset)
);

// File: dv/host_driver_model.sv
// Purpose: driver-side microprocessor on the command/data bus
// Assumes: strobes taken at one rising edge
// Notes: released bus shows the inverse, never a stale word
`timescale 1ns/1ps
module host_driver_model
  import hc_regs_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [DATA_W-1:0] i_rd_data,
  input wire logic i_rd_valid,
  output logic o_cmd_wr = 1'b0,
  output logic o_data_wr = 1'b0,
  output logic o_data_rd = 1'b0,
  output logic [DATA_W-1:0] o_bus_data = 16'hffff
);
  task automatic phase(input int kind, input logic [DATA_W-1:0] v);
    @(posedge i_core_clk);
    #1;
    o_bus_data = v;
    o_cmd_wr = kind == 0;
    o_data_wr = kind == 1;
    o_data_rd = kind == 2;
    @(posedge i_core_clk);
    #1;
    {o_cmd_wr, o_data_wr, o_data_rd} = 3'b000;
    o_bus_data = ~v;
  endtask : phase
  task automatic rd(output logic [DATA_W-1:0] v, output logic ok);
    phase(2, 16'h0000);
    v = i_rd_data;
    ok = i_rd_valid;
  endtask : rd
  task automatic set_len(input logic [DATA_W-1:0] iso, input logic [DATA_W-1:0] async);
    if (async + 2 * iso <= BUFFER_RAM_BYTES) begin
      phase(0, {8'h00, CMD_ISO_LEN_WR});
      phase(1, iso);
      phase(0, {8'h00, CMD_ASYNC_LEN_WR});
      phase(1, async);
    end
  endtask : set_len
endmodule : host_driver_model

// File: dv/hc_misc_buffer_config_regs_bench.sv
// Purpose: self-checking bench for hc_misc_buffer_config_regs
// Assumes: default parameters of the design
// Notes: one task per scenario
`timescale 1ns/1ps
module hc_misc_buffer_config_regs_bench
  import hc_regs_pkg::*;
();
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  wire logic i_cmd_wr, i_data_wr, i_data_rd, o_rd_valid, o_layout_over, o_soft_reset;
  wire logic [DATA_W-1:0] i_bus_data, o_rd_data, o_iso_len, o_async_len;
  wire logic [DATA_W:0] o_iso_one_base, o_async_base;
  wire logic [DATA_W+1:0] o_total_bytes;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  hc_misc_buffer_config_regs hc_misc_buffer_config_regs_i (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_cmd_wr(i_cmd_wr),
    .i_data_wr(i_data_wr),
    .i_data_rd(i_data_rd),
    .i_bus_data(i_bus_data),
    .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid),
    .o_iso_len(o_iso_len),
    .o_async_len(o_async_len),
    .o_iso_one_base(o_iso_one_base),
    .o_async_base(o_async_base),
    .o_total_bytes(o_total_bytes),
    .o_layout_over(o_layout_over),
    .o_soft_reset(o_soft_reset)
  );
  host_driver_model host_driver_model_i (
    .i_core_clk(i_core_clk),
    .i_rd_data(o_rd_data),
    .i_rd_valid(o_rd_valid),
    .o_cmd_wr(i_cmd_wr),
    .o_data_wr(i_data_wr),
    .o_data_rd(i_data_rd),
    .o_bus_data(i_bus_data)
  );
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  task automatic rreg(input logic [7:0] c, input logic [15:0] e, input string n);
    logic [15:0] v;
    logic ok;
    host_driver_model_i.phase(0, {8'h00, c});
    host_driver_model_i.rd(v, ok);
    chk(n, 64'({ok, v}), 64'({1'b1, e}));
  endtask : rreg
  task automatic t_reset_values();
    rreg(CMD_CHIP_ID_RD, 16'h5a01, "chip id");
    rreg(CMD_SCRATCH_RD, SCRATCH_RESET, "scratch");
    rreg(CMD_ISO_LEN_RD, ISO_LEN_RESET, "iso len");
    rreg(CMD_ASYNC_LEN_RD, ASYNC_LEN_RESET, "async len");
    rreg(8'h29, UNMAPPED_READ, "write-only read");
  endtask : t_reset_values
  task automatic t_lengths();
    host_driver_model_i.set_len(16'h0400, 16'h0800);
    host_driver_model_i.phase(0, {8'h00, CMD_SCRATCH_WR});
    host_driver_model_i.phase(1, 16'h1111);
    host_driver_model_i.phase(1, 16'ha55a);
    rreg(CMD_ISO_LEN_RD, 16'h0400, "iso len");
    rreg(CMD_ASYNC_LEN_RD, 16'h0800, "async len");
    rreg(CMD_SCRATCH_RD, 16'ha55a, "scratch");
    chk("iso one base", 64'(o_iso_one_base), 64'h400);
    chk("async base", 64'(o_async_base), 64'h800);
    chk("total", 64'({o_layout_over, o_total_bytes}), 64'h1000);
    // one byte past the budget: stored as written, only flagged
    host_driver_model_i.phase(0, {8'h00, CMD_ASYNC_LEN_WR});
    host_driver_model_i.phase(1, 16'h0801);
    @(posedge i_core_clk);
    #1;
    chk("over budget", 64'({o_layout_over, o_total_bytes}), 64'h41001);
  endtask : t_lengths
  task automatic t_soft_reset();
    logic [15:0] v;
    logic ok;
    host_driver_model_i.phase(0, {8'h00, CMD_SOFT_RESET_WR});
    host_driver_model_i.phase(1, 16'h01f6);
    chk("no pulse", 64'({o_soft_reset, o_iso_len, o_async_len}), 64'h004000801);
    host_driver_model_i.rd(v, ok);
    chk("refused read", 64'(ok), 64'h0);
    host_driver_model_i.phase(1, SOFT_RESET_KEY);
    chk("pulse", 64'({o_soft_reset, o_iso_len, o_async_len}), 64'h100000000);
    rreg(CMD_SCRATCH_RD, SCRATCH_RESET, "scratch cleared");
    chk("layout cleared", 64'({o_layout_over, o_total_bytes, o_async_base}), 64'h0);
    rreg(CMD_CHIP_ID_RD, 16'h5a01, "chip id kept");
  endtask : t_soft_reset
  initial begin
    forever #2 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (2) @(posedge i_core_clk);
    #1;
    i_rst = 1'b0;
    t_reset_values();
    t_lengths();
    t_soft_reset();
    finish_test();
  end
endmodule : hc_misc_buffer_config_regs_bench
